/* design/ubt_pkg.sv */
package ubt_pkg;
  // ****************************************
  // Register offsets (byte addresses)
  // ****************************************
  localparam logic [3:0] ADDR_BAUD = 4'h0;
  localparam logic [3:0] ADDR_CTRL1 = 4'h1;
  localparam logic [3:0] ADDR_ACTRL2 = 4'h2;
  localparam logic [3:0] ADDR_CTRL2 = 4'h3;
  localparam logic [3:0] ADDR_STAT1 = 4'h4;
  localparam logic [3:0] ADDR_STAT2 = 4'h5;
  localparam logic [3:0] ADDR_DATA = 4'h7;
  localparam logic [3:0] ADDR_IRQ_STAT = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MASK = 4'h9;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL1_M = 4;
  localparam int CTRL1_PE = 1;
  localparam int CTRL1_PT = 0;
  localparam int CTRL2_TE = 3;
  localparam int CTRL2_RE = 2;
  localparam int STAT1_TX_BUFFER_EMPTY_FLAG = 7;
  localparam int STAT1_TC = 6;
  localparam int STAT1_RECEIVE_FULL_FLAG = 5;
  localparam int STAT1_FE = 1;
  localparam int STAT1_PF = 0;
  localparam int STAT2_ALTERNATE_MAP_SELECT = 7;
  localparam int ACTRL2_BREAK_FEATURE_ON = 0;
  localparam int IRQ_BRK = 0;
  localparam int IRQ_RXF = 1;
  localparam int IRQ_FE = 2;
  localparam int IRQ_TXE = 3;
  localparam int IRQ_W = 4;
  // ****************************************
  // Reset values and counts
  // ****************************************
  localparam logic [15:0] BAUD_RESET = 16'h0004;
  localparam logic [3:0] OVS_LAST = 4'hf;
  localparam logic [3:0] OVS_MID = 4'h7;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ubt_rx_type;
  typedef enum logic [2:0] {TX_OFF, TX_READY, TX_PRE, TX_START, TX_DATA, TX_STOP} ubt_tx_type;
endpackage

/* design/ubt_baud.sv */
`timescale 1ns/1ps
module ubt_baud
  import ubt_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [15:0] divisor,
  output logic tick
);
  logic [15:0] cnt_r;
  // ****************************************
  // Oversample tick divider
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b0;
    end
    else if (cnt_r >= divisor - 16'h0001)
    begin
      cnt_r <= 16'h0000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
      tick <= 1'b0;
    end
  end
endmodule

/* design/ubt_par.sv */
`timescale 1ns/1ps
module ubt_par
  import ubt_pkg::*;
(
  input wire logic [8:0] data,
  input wire logic nine,
  input wire logic odd,
  output logic bit_out
);
  // Parity over the data bits
  always_comb
  begin
    bit_out = (^data[7:0]) ^ (nine & data[8]) ^ odd;
  end
endmodule

/* design/ubt_top.sv */
// Chosen here: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Functional notes
// - A break starting at the start bit with the feature on loads no byte and leaves the full flag alone.
// - Such a break raises no framing or parity error.
// - A break starting mid-frame loads the partial byte, sets full, framing and (if on) parity error.
// - The break flag sets as soon as a break is recognised.
// - An idle character is all ones, no start, stop or parity bit, length per word-length bit.
// - After the transmitter enable rises, an idle preamble precedes the first frame.
// - Clearing the enable mid-frame lets the frame finish before the line goes idle.
// - Clearing then setting the enable mid-frame queues one idle after the frame.
// - Setting the enable only after the stop bit loses previously written transmit data.
// - With the enable clear and transmission done, the output pin is released.
// - Alternate registers are reached only while the alternate map select bit is one.
module ubt_top
  import ubt_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [7:0] AVS_WRITEDATA,
  output logic [7:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  input wire logic RXD,
  output logic TXD_O,
  output logic TXD_OE,
  output logic IRQ
);
  logic [15:0] baud_r;
  logic [7:0] ctrl1_r;
  logic [7:0] ctrl2_r;
  logic alternate_map_select_r;
  logic break_feature_on_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  logic [8:0] rx_buf_r;
  logic receive_full_flag_r;
  logic fe_r;
  logic pf_r;
  logic [8:0] tx_buf_r;
  logic tx_buffer_empty_flag_r;
  logic tc_r;
  logic ack_r;
  logic tick;
  logic wr_acc;
  logic rd_acc;
  logic tx_on;
  logic nine;
  logic [3:0] nbits;
  logic rx_par_calc;
  logic tx_par_calc;
  logic [7:0] rd_nxt;
  // Receive path
  ubt_rx_type rx_st_r;
  logic [3:0] rx_ovs_r;
  logic [3:0] rx_bit_r;
  logic [8:0] rx_sh_r;
  logic rx_armed_r;
  logic rx_any_high_r;
  logic [8:0] rx_word;
  logic rx_done;
  logic rx_brk;
  // Transmit path
  ubt_tx_type tx_st_r;
  logic [3:0] tx_ovs_r;
  logic [3:0] tx_bit_r;
  logic [9:0] tx_sh_r;
  logic tx_on_d_r;
  logic pre_pend_r;
  logic tx_bit_end;
  logic tx_load;
  assign tx_on = ctrl2_r[CTRL2_TE];
  assign nine = ctrl1_r[CTRL1_M];
  assign nbits = nine ? BITS_9 : BITS_8;
  // ****************************************
  // Avalon slave, one wait state
  // ****************************************
  assign wr_acc = AVS_WRITE && ack_r;
  assign rd_acc = AVS_READ && ack_r;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ack_r <= 1'b0;
      AVS_WAITREQUEST <= 1'b1;
    end
    else
    begin
      ack_r <= (AVS_READ || AVS_WRITE) && !ack_r;
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && !ack_r);
    end
  end
  always_comb
  begin
    rd_nxt = 8'h00;
    unique case (AVS_ADDRESS)
      ADDR_BAUD: rd_nxt = alternate_map_select_r ? {4'h0, irq_stat_r} : baud_r[15:8];
      ADDR_CTRL1: rd_nxt = alternate_map_select_r ? {4'h0, irq_mask_r} : baud_r[7:0];
      ADDR_ACTRL2: rd_nxt = alternate_map_select_r ? {7'h00, break_feature_on_r} : ctrl1_r;
      ADDR_CTRL2: rd_nxt = ctrl2_r;
      ADDR_STAT1: rd_nxt = {tx_buffer_empty_flag_r, tc_r, receive_full_flag_r, 3'h0, fe_r, pf_r};
      ADDR_STAT2: rd_nxt = {alternate_map_select_r, 7'h00};
      ADDR_DATA: rd_nxt = rx_buf_r[7:0];
      ADDR_IRQ_STAT: rd_nxt = {4'h0, irq_stat_r};
      ADDR_IRQ_MASK: rd_nxt = {4'h0, irq_mask_r};
      default: rd_nxt = 8'h00;
    endcase
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      AVS_READDATA <= 8'h00;
    else
      AVS_READDATA <= rd_nxt;
  end
  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      baud_r <= BAUD_RESET;
      ctrl1_r <= 8'h00;
      ctrl2_r <= 8'h00;
      alternate_map_select_r <= 1'b0;
      break_feature_on_r <= 1'b0;
      irq_mask_r <= 4'h0;
    end
    else if (wr_acc)
    begin
      unique case (AVS_ADDRESS)
        ADDR_BAUD:
        begin
          if (alternate_map_select_r)
            ;
          else
            baud_r[15:8] <= AVS_WRITEDATA;
        end
        ADDR_CTRL1:
        begin
          if (alternate_map_select_r)
            irq_mask_r <= AVS_WRITEDATA[IRQ_W-1:0];
          else
            baud_r[7:0] <= AVS_WRITEDATA;
        end
        ADDR_ACTRL2:
        begin
          if (alternate_map_select_r)
            break_feature_on_r <= AVS_WRITEDATA[ACTRL2_BREAK_FEATURE_ON];
          else
            ctrl1_r <= AVS_WRITEDATA;
        end
        ADDR_CTRL2: ctrl2_r <= AVS_WRITEDATA;
        ADDR_STAT2: alternate_map_select_r <= AVS_WRITEDATA[STAT2_ALTERNATE_MAP_SELECT];
        ADDR_IRQ_MASK: irq_mask_r <= AVS_WRITEDATA[IRQ_W-1:0];
        default: ;
      endcase
    end
  end
  ubt_baud u_baud (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .divisor(baud_r),
    .tick(tick)
  );
  ubt_par u_rxpar (
    .data(rx_word),
    .nine(nine),
    .odd(ctrl1_r[CTRL1_PT]),
    .bit_out(rx_par_calc)
  );
  ubt_par u_txpar (
    .data(nine ? tx_buf_r : {2'b00, tx_buf_r[6:0]}),
    .nine(nine),
    .odd(ctrl1_r[CTRL1_PT]),
    .bit_out(tx_par_calc)
  );
  // ****************************************
  // Receiver
  // ****************************************
  assign rx_done = tick && (rx_st_r == RX_STOP) && (rx_ovs_r == OVS_LAST);
  assign rx_brk = rx_done && !RXD && !rx_any_high_r;
  assign rx_word = nine ? rx_sh_r : {1'b0, rx_sh_r[8:1]};
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_st_r <= RX_IDLE;
      rx_ovs_r <= 4'h0;
      rx_bit_r <= 4'h0;
      rx_sh_r <= 9'h000;
      rx_armed_r <= 1'b0;
      rx_any_high_r <= 1'b0;
    end
    else if (!ctrl2_r[CTRL2_RE])
      rx_st_r <= RX_IDLE;
    else if (tick)
    begin
      rx_ovs_r <= rx_ovs_r + 4'h1;
      unique case (rx_st_r)
        RX_IDLE:
        begin
          rx_ovs_r <= 4'h0;
          rx_any_high_r <= 1'b0;
          if (RXD)
            rx_armed_r <= 1'b1;
          if (!RXD && rx_armed_r)
            rx_st_r <= RX_START;
        end
        RX_START:
        begin
          if (rx_ovs_r == OVS_MID)
          begin
            rx_ovs_r <= 4'h0;
            rx_bit_r <= 4'h0;
            rx_st_r <= RXD ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_ovs_r == OVS_LAST)
          begin
            rx_sh_r <= {RXD, rx_sh_r[8:1]};
            rx_any_high_r <= rx_any_high_r | RXD;
            if (rx_bit_r == nbits - 4'h1)
              rx_st_r <= RX_STOP;
            rx_bit_r <= rx_bit_r + 4'h1;
          end
        end
        RX_STOP:
        begin
          if (rx_ovs_r == OVS_LAST)
          begin
            rx_st_r <= RX_IDLE;
            rx_armed_r <= RXD;
          end
        end
        default: rx_st_r <= RX_IDLE;
      endcase
    end
  end
  // Receive buffer and error flags
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rx_buf_r <= 9'h000;
      receive_full_flag_r <= 1'b0;
      fe_r <= 1'b0;
      pf_r <= 1'b0;
    end
    else if (rx_done && !(rx_brk && !rx_any_high_r && break_feature_on_r))
    begin
      rx_buf_r <= rx_word;
      receive_full_flag_r <= 1'b1;
      fe_r <= !RXD;
      pf_r <= ctrl1_r[CTRL1_PE] && rx_par_calc;
    end
    else if (rd_acc && AVS_ADDRESS == ADDR_DATA)
      receive_full_flag_r <= 1'b0;
  end
  // ****************************************
  // Transmitter
  // ****************************************
  assign tx_bit_end = tick && (tx_ovs_r == OVS_LAST);
  assign tx_load = wr_acc && AVS_ADDRESS == ADDR_DATA;
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_on_d_r <= 1'b0;
      pre_pend_r <= 1'b0;
    end
    else
    begin
      tx_on_d_r <= tx_on;
      if (tx_on && !tx_on_d_r)
        pre_pend_r <= 1'b1;
      else if (tx_st_r == TX_PRE && tx_bit_end && tx_bit_r == nbits + 4'h1)
        pre_pend_r <= 1'b0;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_buf_r <= 9'h000;
      tx_buffer_empty_flag_r <= 1'b1;
    end
    else if (tx_st_r == TX_START && tick && tx_ovs_r == 4'h0)
      tx_buffer_empty_flag_r <= 1'b1;
    else if (tx_load)
    begin
      tx_buf_r <= {1'b0, AVS_WRITEDATA};
      tx_buffer_empty_flag_r <= 1'b0;
    end
    else if (tx_st_r == TX_OFF && !tx_on)
      tx_buffer_empty_flag_r <= 1'b1;
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      tx_st_r <= TX_OFF;
      tx_ovs_r <= 4'h0;
      tx_bit_r <= 4'h0;
      tx_sh_r <= 10'h3ff;
      tc_r <= 1'b1;
    end
    else if (tick)
    begin
      tx_ovs_r <= tx_ovs_r + 4'h1;
      unique case (tx_st_r)
        TX_OFF:
        begin
          tx_ovs_r <= 4'h0;
          if (tx_on)
            tx_st_r <= TX_READY;
        end
        TX_READY:
        begin
          tx_ovs_r <= 4'h0;
          tx_bit_r <= 4'h0;
          if (!tx_on)
            tx_st_r <= TX_OFF;
          else if (pre_pend_r)
          begin
            tx_st_r <= TX_PRE;
            tc_r <= 1'b0;
          end
          else if (!tx_buffer_empty_flag_r)
          begin
            tx_st_r <= TX_START;
            tc_r <= 1'b0;
          end
          else
            tc_r <= 1'b1;
        end
        TX_PRE:
        begin
          if (tx_ovs_r == OVS_LAST)
          begin
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == nbits + 4'h1)
              tx_st_r <= TX_READY;
          end
        end
        TX_START:
        begin
          if (tx_ovs_r == 4'h0)
          begin
            tx_sh_r <= {tx_par_calc, tx_buf_r};
            if (ctrl1_r[CTRL1_PE])
              tx_sh_r <= nine ? {tx_par_calc, tx_buf_r} : {2'b11, tx_par_calc, tx_buf_r[6:0]};
          end
          if (tx_ovs_r == OVS_LAST)
          begin
            tx_bit_r <= 4'h0;
            tx_st_r <= TX_DATA;
          end
        end
        TX_DATA:
        begin
          if (tx_ovs_r == OVS_LAST)
          begin
            tx_sh_r <= {1'b1, tx_sh_r[9:1]};
            tx_bit_r <= tx_bit_r + 4'h1;
            if (tx_bit_r == nbits - 4'h1)
              tx_st_r <= TX_STOP;
          end
        end
        TX_STOP:
        begin
          if (tx_ovs_r == OVS_LAST)
            tx_st_r <= tx_on ? TX_READY : TX_OFF;
        end
        default: tx_st_r <= TX_OFF;
      endcase
    end
  end
  // Line drive
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      TXD_O <= 1'b1;
      TXD_OE <= 1'b0;
    end
    else
    begin
      TXD_O <= (tx_st_r == TX_START) ? 1'b0 : (tx_st_r == TX_DATA) ? tx_sh_r[0] : 1'b1;
      TXD_OE <= !(tx_st_r == TX_OFF && !tx_on);
    end
  end
  // ****************************************
  // Interrupt status and mask
  // ****************************************
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      irq_stat_r <= 4'h0;
    else
    begin
      for (int i = 0; i < IRQ_W; i++)
      begin
        if (wr_acc && AVS_ADDRESS == ADDR_IRQ_STAT && AVS_WRITEDATA[i])
          irq_stat_r[i] <= 1'b0;
      end
      if (rx_brk)
        irq_stat_r[IRQ_BRK] <= 1'b1;
      if (rx_done && !(rx_brk && !rx_any_high_r && break_feature_on_r))
        irq_stat_r[IRQ_RXF] <= 1'b1;
      if (rx_done && !RXD && !(!rx_any_high_r && break_feature_on_r))
        irq_stat_r[IRQ_FE] <= 1'b1;
      if (tx_st_r == TX_START && tick && tx_ovs_r == 4'h0)
        irq_stat_r[IRQ_TXE] <= 1'b1;
    end
  end
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
      IRQ <= 1'b0;
    else
      IRQ <= |(irq_stat_r & irq_mask_r);
  end
endmodule

/* tb/ubt_chk.sv */
`timescale 1ns/1ps
// ****************************************
// Port checker
// ****************************************
module ubt_chk
  import ubt_pkg::*;
(
  input wire logic CLK_SYS,
  input wire logic RST_N,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [7:0] AVS_WRITEDATA,
  input wire logic [7:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic RXD,
  input wire logic TXD_O,
  input wire logic TXD_OE,
  input wire logic IRQ
);
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RST_N);
  logic [5:0] run_r;
  logic prev_r;
  // Length of the current line level, modulo one bit time
  always_ff @(posedge CLK_SYS or negedge RST_N)
  begin
    if (!RST_N)
    begin
      run_r <= 6'h00;
      prev_r <= 1'b1;
    end
    else
    begin
      run_r <= (TXD_O != prev_r) ? 6'h01 : run_r + 6'h01;
      prev_r <= TXD_O;
    end
  end
  sequence s_req;
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST;
  endsequence
  sequence s_pre_idle;
    TXD_O [*8];
  endsequence
  sequence s_start_bit;
    (!TXD_O && TXD_OE) [*8] ##1 TXD_OE;
  endsequence
  property p_ack;
    s_req |=> !AVS_WAITREQUEST;
  endproperty
  property p_no_req;
    !(AVS_READ || AVS_WRITE) |=> AVS_WAITREQUEST;
  endproperty
  property p_wait_one;
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST;
  endproperty
  property p_pre_idle;
    $rose(TXD_OE) |-> s_pre_idle;
  endproperty
  property p_release;
    $fell(TXD_OE) |-> $past(TXD_O);
  endproperty
  property p_oe_hold;
    TXD_OE && !TXD_O |=> TXD_OE;
  endproperty
  property p_start;
    TXD_OE && $fell(TXD_O) |-> s_start_bit;
  endproperty
  property p_bit_len;
    TXD_OE && TXD_O && !prev_r |-> run_r == 6'h00;
  endproperty
  a_ack: assert property (p_ack) else $error("request not answered next cycle");
  a_no_req: assert property (p_no_req) else $error("answer without request");
  a_wait_one: assert property (p_wait_one) else $error("answer longer than one cycle");
  a_pre_idle: assert property (p_pre_idle) else $error("enable not followed by idle");
  a_release: assert property (p_release) else $error("pin released inside a frame");
  a_oe_hold: assert property (p_oe_hold) else $error("pin released on a low bit");
  a_start: assert property (p_start) else $error("start bit cut short");
  a_bit_len: assert property (p_bit_len) else $error("low run not whole bit times");
endmodule

/* tb/ubt_remote.sv */
`timescale 1ns/1ps
// ****************************************
// Remote transceiver, drives the line
// ****************************************
module ubt_remote
(
  input wire logic clk_sys,
  output logic rxd
);
  initial rxd = 1'b1;
  // Bits LSB first, 64 clocks each, then idle high
  task send(input logic [11:0] bits, input int n);
    begin
      for (int i = 0; i < n; i++)
      begin
        @(posedge clk_sys);
        rxd <= bits[i];
        repeat (63) @(posedge clk_sys);
      end
      @(posedge clk_sys);
      rxd <= 1'b1;
    end
  endtask
endmodule

/* tb/tb_ubt_top.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, e); end end
module tb_ubt_top
  import ubt_pkg::*;
;
  typedef struct {logic [3:0] a; logic [7:0] d; logic [7:0] e;} ubt_row_type;
  logic clk_sys, rst_n, avs_read, avs_write, avs_waitrequest, rxd, txd_o, txd_oe, irq;
  logic [3:0] avs_address;
  logic [7:0] avs_writedata, avs_readdata, q;
  logic [9:0] fr;
  int err_count = 0, comparisons = 0, cyc = 0, t0, n;
  ubt_row_type rows[7] = '{'{ADDR_IRQ_MASK, 8'h0f, 8'h0f}, '{4'h1, 8'h04, 8'h04}, '{ADDR_BAUD, 8'h00, 8'h00},
    '{4'h6, 8'haa, 8'h00}, '{ADDR_STAT2, 8'h80, 8'h80}, '{4'h2, 8'h01, 8'h01}, '{ADDR_STAT2, 8'h00, 8'h00}};
  ubt_top ubt_top_i (.CLK_SYS(clk_sys), .RST_N(rst_n), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .RXD(rxd), .TXD_O(txd_o), .TXD_OE(txd_oe), .IRQ(irq));
  ubt_remote ubt_remote_i (.clk_sys(clk_sys), .rxd(rxd));
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ****************************************
  // Bus and line tasks
  // ****************************************
  task bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int k;
    begin
      k = 0;
      @(posedge clk_sys);
      avs_write <= w;
      avs_read <= !w;
      avs_address <= a;
      avs_writedata <= d;
      @(posedge clk_sys);
      while (avs_waitrequest !== 1'b0 && k < 50)
      begin
        k++;
        @(posedge clk_sys);
      end
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      if (k >= 50) err_count++;
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask
  task rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      `CHK(q & m, e)
    end
  endtask
  task wait_sig(input logic oe, input logic v);
    int k;
    begin
      k = 0;
      while ((oe ? txd_oe : txd_o) !== v && k < 4000)
      begin
        k++;
        @(posedge clk_sys);
      end
      if (k >= 4000) err_count++;
    end
  endtask
  task get_frame;
    begin
      repeat (32) @(posedge clk_sys);
      for (int i = 0; i < 10; i++)
      begin
        fr[i] = txd_o;
        repeat (64) @(posedge clk_sys);
      end
    end
  endtask
  task complete_run;
    begin
      $display("err_count=%0d comparisons=%0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0)
        $display("*** PASS ***");
      else
        $display("*** FAIL ***");
      $finish;
    end
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    complete_run;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial
  begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 8'h00;
    repeat (10) @(posedge clk_sys);
    `CHK({avs_waitrequest, avs_readdata, txd_oe, irq, txd_o}, 12'h801)
    rst_n <= 1'b1;
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, 8'hff, rows[i].e);
    end
    rd(4'h2, 8'hff, 8'h00);
    wr(ADDR_CTRL2, 8'h04);
    wr(ADDR_IRQ_STAT, 8'h0f);
    ubt_remote_i.send(12'h000, 11);
    repeat (64) @(posedge clk_sys);
    rd(ADDR_STAT1, 8'h23, 8'h00);
    rd(ADDR_IRQ_STAT, 8'h07, 8'h01);
    `CHK(irq, 1'b1)
    wr(4'h2, 8'h02);
    wr(ADDR_IRQ_STAT, 8'h0f);
    ubt_remote_i.send(12'h002, 11);
    repeat (64) @(posedge clk_sys);
    rd(ADDR_STAT1, 8'h23, 8'h23);
    rd(ADDR_IRQ_STAT, 8'h07, 8'h06);
    rd(ADDR_DATA, 8'hff, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h00);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wr(ADDR_IRQ_MASK, 8'h04);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b1)
    wr(ADDR_IRQ_STAT, 8'h0f);
    repeat (2) @(posedge clk_sys);
    `CHK(irq, 1'b0)
    wr(4'h2, 8'h00);
    wr(ADDR_CTRL2, 8'h0c);
    t0 = cyc;
    wr(ADDR_DATA, 8'h55);
    wait_sig(1'b0, 1'b0);
    `CHK((cyc - t0 >= 600) && (cyc - t0 <= 720), 1'b1)
    get_frame;
    `CHK(fr, {1'b1, 8'h55, 1'b0})
    wr(ADDR_DATA, 8'ha5);
    wait_sig(1'b0, 1'b0);
    t0 = cyc;
    repeat (64) @(posedge clk_sys);
    wr(ADDR_CTRL2, 8'h04);
    wr(ADDR_CTRL2, 8'h0c);
    wr(ADDR_DATA, 8'h3c);
    while (cyc - t0 < 660) @(posedge clk_sys);
    wait_sig(1'b0, 1'b0);
    `CHK((cyc - t0 >= 1280) && (cyc - t0 <= 1350), 1'b1)
    get_frame;
    `CHK(fr, {1'b1, 8'h3c, 1'b0})
    wr(ADDR_DATA, 8'h81);
    wait_sig(1'b0, 1'b0);
    t0 = cyc;
    wr(ADDR_DATA, 8'h7e);
    wr(ADDR_CTRL2, 8'h04);
    wait_sig(1'b1, 1'b0);
    `CHK((cyc - t0 >= 640) && (cyc - t0 <= 720), 1'b1)
    repeat (8) @(posedge clk_sys);
    `CHK(txd_oe, 1'b0)
    wr(ADDR_CTRL2, 8'h0c);
    n = 0;
    repeat (1500)
    begin
      @(posedge clk_sys);
      if (txd_o !== 1'b1) n++;
    end
    `CHK(n == 0, 1'b1)
    complete_run;
  end
endmodule
bind ubt_top ubt_chk ubt_chk_i (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .AVS_ADDRESS(AVS_ADDRESS),
  .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .RXD(RXD), .TXD_O(TXD_O), .TXD_OE(TXD_OE), .IRQ(IRQ));
